// ---- core/fp_panel.sv ----
// The address map and register access over APB were chosen for this implementation.
`include "fp_defines.svh"

module fp_panel #(
  parameter int unsigned DEB_CYCLES = `FP_DEB_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        reset_button_n,
  input  wire logic        abort_button_n,
  input  wire logic        board_failure_flag,
  input  wire logic [3:0]  cpu_status,
  input  wire logic        transfer_in_progress_n,
  input  wire logic        sys_controller_role,
  input  wire logic        eth_bus_master,
  input  wire logic        vme_as_driven,
  input  wire logic        vme_local_master,
  input  wire logic        lan_power_ok,
  input  wire logic        disk_active,
  output logic             board_reset_n,
  output logic             sysreset_n,
  output logic             sysreset_oe_n,
  output logic             abort_irq,
  output logic [2:0]       abort_irq_level,
  output logic             irq,
  output logic             fail_lamp,
  output logic             status_lamp,
  output logic             run_lamp,
  output logic             system_controller_lamp,
  output logic             network_lamp,
  output logic             network_power_lamp,
  output logic             disk_lamp,
  output logic             backplane_lamp
);
  import fp_pkg::*;

  logic [31:0]   ctrl_reg;
  logic [31:0]   ctrl_next;
  logic [2:0]    status_reg;
  logic [2:0]    status_next;
  logic [2:0]    mask_reg;
  logic [2:0]    mask_next;
  logic [31:0]   prdata_reg;
  logic [31:0]   prdata_next;
  logic          pslverr_reg;
  logic          pslverr_next;
  fp_btn_state_t rst_state_reg;
  fp_btn_state_t rst_state_next;
  logic [4:0]    rst_cnt_reg;
  logic [4:0]    rst_cnt_next;
  logic          sysrst_reg;
  logic          sysrst_next;
  fp_lamps_t     lamp_reg;
  fp_lamps_t     lamp_next;
  logic [7:0]    in_s1_reg;
  logic [7:0]    in_s2_reg;
  logic [3:0]    pst_s1_reg;
  logic [3:0]    pst_s2_reg;
  logic          fail_prev_reg;
  logic          rst_held;
  logic          rst_press;
  logic          abt_press;
  logic          wr;
  logic          rd;
  logic          addr_ok;

  // Both buttons pass two flops then a stability counter
  fp_debounce #(.STABLE(DEB_CYCLES)) u_rst_deb (
    .pclk        (pclk),
    .presetn     (presetn),
    .raw_n       (reset_button_n),
    .pressed     (rst_held),
    .press_pulse (rst_press)
  );

  fp_debounce #(.STABLE(DEB_CYCLES)) u_abt_deb (
    .pclk        (pclk),
    .presetn     (presetn),
    .raw_n       (abort_button_n),
    .pressed     (),
    .press_pulse (abt_press)
  );

  // Board inputs are asynchronous to pclk: two flops each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_s1_reg  <= 8'h00;
      in_s2_reg  <= 8'h00;
      pst_s1_reg <= 4'h0;
      pst_s2_reg <= 4'h0;
    end else begin
      in_s1_reg  <= {disk_active, lan_power_ok, vme_local_master,
                     vme_as_driven, eth_bus_master, sys_controller_role,
                     transfer_in_progress_n, board_failure_flag};
      in_s2_reg  <= in_s1_reg;
      pst_s1_reg <= cpu_status;
      pst_s2_reg <= pst_s1_reg;
    end
  end

  assign wr      = psel && penable && pwrite;
  assign rd      = psel && !penable && !pwrite;
  assign addr_ok = (paddr == `FP_ADDR_CTRL) || (paddr == `FP_ADDR_STATUS)
                || (paddr == `FP_ADDR_MASK) || (paddr == `FP_ADDR_LAMPS)
                || (paddr == `FP_ADDR_INPUTS);

  // Register file, sticky status with set winning over clear
  always_comb begin
    ctrl_next    = ctrl_reg;
    mask_next    = mask_reg;
    status_next  = status_reg;
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    if (wr && addr_ok) begin
      if (paddr == `FP_ADDR_CTRL) begin
        ctrl_next = pwdata & 32'h0000_0073;
      end else if (paddr == `FP_ADDR_STATUS) begin
        status_next = status_reg & ~pwdata[2:0];
      end else if (paddr == `FP_ADDR_MASK) begin
        mask_next = pwdata[2:0];
      end
    end
    if (psel && !penable) begin
      pslverr_next = !addr_ok;
    end
    if (rd) begin
      if (paddr == `FP_ADDR_CTRL) begin
        prdata_next = ctrl_reg;
      end else if (paddr == `FP_ADDR_STATUS) begin
        prdata_next = {29'h0, status_reg};
      end else if (paddr == `FP_ADDR_MASK) begin
        prdata_next = {29'h0, mask_reg};
      end else if (paddr == `FP_ADDR_LAMPS) begin
        prdata_next = {24'h0, backplane_lamp, disk_lamp, network_power_lamp,
                       network_lamp, system_controller_lamp, run_lamp,
                       status_lamp, fail_lamp};
      end else if (paddr == `FP_ADDR_INPUTS) begin
        prdata_next = {16'h0, pst_s2_reg, 3'h0, rst_held, in_s2_reg};
      end else begin
        prdata_next = 32'h0000_0000;
      end
    end
    // Abort counts only while enabled and stays until cleared
    if (abt_press && ctrl_reg[`FP_CTRL_ABT_EN]) begin
      status_next[`FP_ST_ABORT] = 1'b1;
    end
    if (rst_press && ctrl_reg[`FP_CTRL_RST_EN]) begin
      status_next[`FP_ST_RESET] = 1'b1;
    end
    if (in_s2_reg[0] && !fail_prev_reg) begin
      status_next[`FP_ST_FAIL] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg      <= `FP_CTRL_RESET;
      mask_reg      <= `FP_MASK_RESET;
      status_reg    <= 3'h0;
      prdata_reg    <= 32'h0000_0000;
      pslverr_reg   <= 1'b0;
      fail_prev_reg <= 1'b0;
    end else begin
      ctrl_reg      <= ctrl_next;
      mask_reg      <= mask_next;
      status_reg    <= status_next;
      prdata_reg    <= prdata_next;
      pslverr_reg   <= pslverr_next;
      fail_prev_reg <= in_s2_reg[0];
    end
  end

  // Read data is captured in setup, so access completes in one cycle
  assign pready  = psel && penable;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg && psel && penable;

  assign irq             = |(status_reg & mask_reg);
  assign abort_irq       = status_reg[`FP_ST_ABORT];
  assign abort_irq_level = ctrl_reg[`FP_CTRL_LVL_MSB:`FP_CTRL_LVL_LSB];

  // Reset pulse: a fixed stretch, then wait for button release so a
  // long press does not retrigger
  always_comb begin
    rst_state_next = rst_state_reg;
    rst_cnt_next   = rst_cnt_reg;
    sysrst_next    = sysrst_reg;
    case (rst_state_reg)
      FP_BTN_IDLE: begin
        if (rst_press && ctrl_reg[`FP_CTRL_RST_EN]) begin
          rst_state_next = FP_BTN_HELD;
          rst_cnt_next   = 5'h00;
          sysrst_next    = in_s2_reg[2];
        end
      end
      FP_BTN_HELD: begin
        if (rst_cnt_reg == 5'(`FP_RST_CYCLES - 1)) begin
          rst_state_next = FP_BTN_WAIT;
          sysrst_next    = 1'b0;
        end else begin
          rst_cnt_next = rst_cnt_reg + 5'h01;
        end
      end
      FP_BTN_WAIT: begin
        if (!rst_held) begin
          rst_state_next = FP_BTN_IDLE;
        end
      end
      default: begin
        rst_state_next = FP_BTN_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_state_reg <= FP_BTN_IDLE;
      rst_cnt_reg   <= 5'h00;
      sysrst_reg    <= 1'b0;
    end else begin
      rst_state_reg <= rst_state_next;
      rst_cnt_reg   <= rst_cnt_next;
      sysrst_reg    <= sysrst_next;
    end
  end

  // Active low outputs; open-drain backplane line enabled low
  assign board_reset_n = !(rst_state_reg == FP_BTN_HELD);
  assign sysreset_n    = 1'b0;
  assign sysreset_oe_n = !sysrst_reg;

  // Lamps registered from the synchronised inputs
  always_comb begin
    lamp_next    = lamp_reg;
    lamp_next[0] = in_s2_reg[0];
    lamp_next[1] = (pst_s2_reg == `FP_PST_HALT);
    lamp_next[2] = !in_s2_reg[1];
    lamp_next[3] = in_s2_reg[2];
    lamp_next[4] = in_s2_reg[3];
    lamp_next[5] = in_s2_reg[4] || in_s2_reg[5];
    lamp_next[6] = in_s2_reg[7];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamp_reg <= 7'h00;
    end else begin
      lamp_reg <= lamp_next;
    end
  end

  // Eight lamps; the power lamp follows its sense line
  assign fail_lamp              = lamp_reg[0];
  assign status_lamp            = lamp_reg[1];
  assign run_lamp               = lamp_reg[2];
  assign system_controller_lamp = lamp_reg[3];
  assign network_lamp           = lamp_reg[4];
  assign backplane_lamp         = lamp_reg[5];
  assign disk_lamp              = lamp_reg[6];
  assign network_power_lamp     = in_s2_reg[6];
endmodule

// ---- core/fp_defines.svh ----
`ifndef FP_DEFINES_SVH
`define FP_DEFINES_SVH

// APB register byte addresses
`define FP_ADDR_CTRL      12'h000
`define FP_ADDR_STATUS    12'h004
`define FP_ADDR_MASK      12'h008
`define FP_ADDR_LAMPS     12'h00C
`define FP_ADDR_INPUTS    12'h010

// Control fields
`define FP_CTRL_RST_EN    0
`define FP_CTRL_ABT_EN    1
`define FP_CTRL_LVL_LSB   4
`define FP_CTRL_LVL_MSB   6
`define FP_CTRL_RESET     32'h0000_0001

// Status and mask fields
`define FP_ST_ABORT       0
`define FP_ST_RESET       1
`define FP_ST_FAIL        2
`define FP_ST_W           3
`define FP_MASK_RESET     3'h0

// Processor halt encoding on the status lines
`define FP_PST_HALT       4'hF

// Debounce: stable time in us and derived cycles at 100 MHz
`define FP_CLK_MHZ        100
`define FP_DEB_US         10000
`define FP_DEB_CYCLES     (`FP_DEB_US * `FP_CLK_MHZ)

// Length of the reset pulse in cycles
`define FP_RST_CYCLES     16

`endif

// ---- core/fp_pkg.sv ----
package fp_pkg;
  typedef enum logic [2:0] {
    FP_BTN_IDLE = 3'b001,
    FP_BTN_HELD = 3'b010,
    FP_BTN_WAIT = 3'b100
  } fp_btn_state_t;

  typedef logic [6:0] fp_lamps_t;
endpackage

// ---- core/fp_debounce.sv ----
`include "fp_defines.svh"

module fp_debounce #(
  parameter int unsigned STABLE = 1000
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic raw_n,
  output logic      pressed,
  output logic      press_pulse
);
  logic [1:0]  sync_reg;
  logic [1:0]  sync_next;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic        state_reg;
  logic        state_next;
  logic        pulse_reg;
  logic        pulse_next;
  logic        level;

  // Button is active low; sync_reg[0] is seen only by sync_reg[1]
  assign level = ~sync_reg[1];

  always_comb begin
    sync_next  = {sync_reg[0], raw_n};
    cnt_next   = cnt_reg;
    state_next = state_reg;
    pulse_next = 1'b0;
    if (level == state_reg) begin
      cnt_next = 32'h0000_0000;
    end else if (cnt_reg >= STABLE - 1) begin
      cnt_next   = 32'h0000_0000;
      state_next = level;
      pulse_next = level;
    end else begin
      cnt_next = cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_reg  <= 2'h3;
      cnt_reg   <= 32'h0000_0000;
      state_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end else begin
      sync_reg  <= sync_next;
      cnt_reg   <= cnt_next;
      state_reg <= state_next;
      pulse_reg <= pulse_next;
    end
  end

  assign pressed     = state_reg;
  assign press_pulse = pulse_reg;
endmodule

// ---- tb/fp_panel_sva.sv ----
`include "fp_defines.svh"

module fp_panel_chk (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       board_failure_flag,
  input wire logic [3:0] cpu_status,
  input wire logic       transfer_in_progress_n,
  input wire logic       sys_controller_role,
  input wire logic       eth_bus_master,
  input wire logic       vme_as_driven,
  input wire logic       vme_local_master,
  input wire logic       board_reset_n,
  input wire logic       sysreset_oe_n,
  input wire logic       abort_irq,
  input wire logic       fail_lamp,
  input wire logic       status_lamp,
  input wire logic       run_lamp,
  input wire logic       system_controller_lamp,
  input wire logic       network_lamp,
  input wire logic       backplane_lamp
);
  logic [4:0] low_cnt;
  logic [4:0] low_next;
  always_comb low_next = board_reset_n ? 5'h00 : low_cnt + 5'h01;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_cnt <= 5'h00;
    else low_cnt <= low_next;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Lamps lag inputs by three cycles, so look back only past reset
  chk_fail_lamp: assert property ($past(presetn, 3) |->
    fail_lamp == $past(board_failure_flag, 3)) else $error("fail lamp");
  chk_halt_lamp: assert property ($past(presetn, 3) |->
    status_lamp == ($past(cpu_status, 3) == `FP_PST_HALT))
    else $error("status lamp");
  chk_run_lamp: assert property ($past(presetn, 3) |->
    run_lamp == !$past(transfer_in_progress_n, 3)) else $error("run lamp");
  chk_system_controller_lamp_lamp: assert property ($past(presetn, 3) |->
    system_controller_lamp == $past(sys_controller_role, 3))
    else $error("controller lamp");
  chk_net_lamp: assert property ($past(presetn, 3) |->
    network_lamp == $past(eth_bus_master, 3)) else $error("network lamp");
  chk_bp_lamp: assert property ($past(presetn, 3) |->
    backplane_lamp == $past(vme_as_driven | vme_local_master, 3))
    else $error("backplane lamp");
  chk_reset_width: assert property ($rose(board_reset_n) |->
    low_cnt == 5'h10) else $error("reset pulse width");
  chk_sysreset_pair: assert property (!sysreset_oe_n |->
    !board_reset_n) else $error("backplane reset alone");
  cover property ($rose(board_reset_n));
  cover property ($fell(sysreset_oe_n));
  cover property ($rose(abort_irq));
endmodule

bind fp_panel fp_panel_chk u_chk (.*);

// ---- tb/fp_operator.sv ----
module fp_operator (
  input  wire logic pclk,
  input  wire logic push_rst,
  input  wire logic push_abt,
  output logic      reset_button_n,
  output logic      abort_button_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] age_r = 2'h0;
  logic [1:0] age_a = 2'h0;
  // Contacts chatter once on closing; an open contact is pulled high
  initial begin
    reset_button_n = 1'h1;
    abort_button_n = 1'h1;
  end
  always @(posedge pclk) begin
    age_r <= push_rst ? {age_r[0], 1'h1} : 2'h0;
    age_a <= push_abt ? {age_a[0], 1'h1} : 2'h0;
    reset_button_n <= !push_rst || age_r == 2'h1;
    abort_button_n <= !push_abt || age_a == 2'h1;
  end
endmodule

// ---- tb/tb_front_panel_switch_and_lamp_logic.sv ----
`include "fp_defines.svh"

module tb_front_panel_switch_and_lamp_logic;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'h0, presetn = 1'h0, push_r = 1'h0, push_a = 1'h0;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, rb_n, ab_n, brst_n, srst_n, srst_oe_n;
  logic        a_irq, irq;
  logic [8:0]  v = 9'h000;
  logic [2:0]  a_lvl;
  logic [7:0]  lamps;
  int          error_cnt = 0, samples_checked = 0, n;

  fp_operator op (.pclk(pclk), .push_rst(push_r), .push_abt(push_a),
    .reset_button_n(rb_n), .abort_button_n(ab_n));
  fp_panel #(.DEB_CYCLES(4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reset_button_n(rb_n),
    .abort_button_n(ab_n), .board_failure_flag(v[8]),
    .cpu_status(v[7] ? `FP_PST_HALT : 4'hE),
    .transfer_in_progress_n(v[6]), .sys_controller_role(v[5]),
    .eth_bus_master(v[4]), .vme_as_driven(v[3]), .vme_local_master(v[2]),
    .lan_power_ok(v[1]), .disk_active(v[0]), .board_reset_n(brst_n),
    .sysreset_n(srst_n), .sysreset_oe_n(srst_oe_n), .abort_irq(a_irq),
    .abort_irq_level(a_lvl), .irq(irq), .fail_lamp(lamps[7]),
    .status_lamp(lamps[6]), .run_lamp(lamps[5]),
    .system_controller_lamp(lamps[4]), .network_lamp(lamps[3]),
    .network_power_lamp(lamps[2]), .disk_lamp(lamps[1]),
    .backplane_lamp(lamps[0]));

  initial forever #5 pclk = ~pclk;

  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic timeout;
    error_cnt++;
    final_report();
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge pclk);
  endtask
  // One idle cycle after each transfer keeps drivers single per step
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    rd = prdata;
    err = pslverr;
    if (n == 20) timeout();
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic wait_ev(bit abt);
    for (n = 0; n < 60; n++) begin
      @(posedge pclk);
      if (abt ? a_irq === 1'h1 : brst_n === 1'h0) break;
    end
    if (n == 60) timeout();
  endtask

  task automatic t_reset;
    apb(0, `FP_ADDR_CTRL, 0);
    chk("ctrl reset", rd, `FP_CTRL_RESET);
    apb(0, 12'h020, 0);
    chk("unmapped err", err, 1);
    chk("unmapped data", rd, 0);
    $display("reset test done");
  endtask
  task automatic t_lamps;
    logic [8:0] pat[5] = '{9'h155, 9'h0AA, 9'h000, 9'h1FF, 9'h020};
    logic [7:0] e;
    foreach (pat[i]) begin
      v <= pat[i];
      tick(5);
      e = {pat[i][8:7], !pat[i][6], pat[i][5:4], pat[i][1:0], |pat[i][3:2]};
      chk("lamps", lamps, e);
    end
    $display("lamp test done");
  endtask
  task automatic t_reset_button;
    int w;
    push_r <= 1'h1;
    wait_ev(0);
    chk("sysreset drive", {srst_oe_n, srst_n}, 0);
    for (w = 0; w < 40 && brst_n === 1'h0; w++) @(posedge pclk);
    chk("reset pulse cycles", w, `FP_RST_CYCLES);
    push_r <= 1'h0;
    tick(30);
    apb(0, `FP_ADDR_STATUS, 0);
    chk("reset press flag", rd[`FP_ST_RESET], 1);
    apb(1, `FP_ADDR_CTRL, 0);
    push_r <= 1'h1;
    for (w = 0; w < 40 && brst_n !== 1'h0; w++) @(posedge pclk);
    chk("disabled press", w, 40);
    push_r <= 1'h0;
    tick(30);
    $display("reset button test done");
  endtask
  task automatic t_abort;
    push_a <= 1'h1;
    tick(30);
    chk("abort disabled", a_irq, 0);
    push_a <= 1'h0;
    tick(30);
    apb(1, `FP_ADDR_CTRL, 32'h0000_0052);
    apb(1, `FP_ADDR_MASK, 32'h0000_0001);
    push_a <= 1'h1;
    wait_ev(1);
    chk("irq level", a_lvl, 5);
    push_a <= 1'h0;
    tick(30);
    chk("abort held", {a_irq, irq}, 3);
    apb(1, `FP_ADDR_MASK, 0);
    chk("masked irq", irq, 0);
    apb(1, `FP_ADDR_STATUS, 32'h0000_0001);
    chk("abort cleared", a_irq, 0);
    $display("abort test done");
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset();
    t_lamps();
    t_reset_button();
    t_abort();
    final_report();
  end
endmodule
